// File: hw/ddil_pkg.sv
// Purpose: Shared constants and types for the dual converter input latch block
// Assumes: 50 MHz system clock; all pin inputs synchronous to it
// Notes:   Register offsets are byte addresses on the Avalon-MM slave
package ddil_pkg;
    localparam int DATA_W_DEF = 14;

    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CODE1  = 4'h8;
    localparam logic [3:0] OFS_CODE2  = 4'hC;

    localparam int CTRL_SLEEP_BIT = 0;
    localparam int ST_MODE_BIT    = 0;
    localparam int ST_AWAKE_BIT   = 1;
    localparam int ST_SYNCED_BIT  = 2;
    localparam int ST_PHASE_BIT   = 3;

    localparam logic CTRL_SLEEP_RST = 1'b0;
    localparam logic MODE_DUAL      = 1'b1;
    localparam logic STEER_CH1      = 1'b1;

    localparam int CLK_MHZ         = 50;
    localparam int MAX_UPDATE_MSPS = 125;
    localparam int SLEEP_ENTER_NS  = 50;
    localparam int WAKE_US         = 5;
    localparam int WAKE_CYCLES     = WAKE_US * CLK_MHZ;
    localparam int ENTER_CYCLES    = ((SLEEP_ENTER_NS * CLK_MHZ) / 1000 < 1) ? 1
                                   : (SLEEP_ENTER_NS * CLK_MHZ) / 1000;

    typedef enum logic [3:0] {
        IL_WAIT = 4'b0001,
        IL_HELD = 4'b0010,
        IL_LOAD = 4'b0100,
        IL_SKIP = 4'b1000
    } ddil_il_state_t;

    typedef struct packed {
        logic strobe;
        logic clock;
    } ddil_ctl_t;
endpackage

// File: hw/ddil_edge_det.sv
// Purpose: Rising edge detection for sampled strobe and clock pins
// Assumes: Inputs synchronous to clk
// Notes:   One pulse per low-to-high change
`timescale 1ns/1ps
module ddil_edge_det #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] sig,
    output logic      [W-1:0] rise
);
    logic [W-1:0] prev_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sig;
        end
    end

    assign rise = sig & ~prev_reg;
endmodule // ddil_edge_det

// File: hw/ddil_sleep_ctl.sv
// Purpose: Power-down sequencing, immediate sleep and timed wake-up
// Assumes: sleep_req already combines pin and software request
// Notes:   Awake at reset; wake takes WAKE_CYC cycles after release
`timescale 1ns/1ps
module ddil_sleep_ctl
    import ddil_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic sleep_req,
    output logic      awake
);
    logic       awake_reg;
    logic [8:0] cnt_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awake_reg <= 1'b1;
            cnt_reg   <= '0;
        end else if (sleep_req) begin
            awake_reg <= 1'b0;
            cnt_reg   <= '0;
        end else if (!awake_reg) begin
            cnt_reg <= cnt_reg + 9'h001;
            if (cnt_reg == 9'(WAKE_CYC - 1)) begin
                awake_reg <= 1'b1;
            end
        end
    end

    assign awake = awake_reg;

    wake_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(awake_reg) |-> $past(cnt_reg) == 9'(WAKE_CYC - 1) && !$past(sleep_req))
        else $error("wake-up ended before its full count");
    sleep_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
        sleep_req |=> !awake_reg)
        else $error("sleep request did not drop awake");
endmodule // ddil_sleep_ctl

// File: hw/ddil_top.sv
// Purpose: Double-buffered input latches for a dual current-output converter
// Assumes: Pins are sampled on clk; register access over Avalon-MM
// Notes:   Codes out stand for true and complementary current drive
// Operation
// - Mode high: two independent ports, each with own strobe and clock.
// - Mode low: port one strobe/clock pair, port two steer and sync hold.
// - Channel words are unsigned straight binary, 10, 12 or 14 bits wide.
// - All-ones gives full-scale true output; complement carries the remainder.
// - Strobe rise fills input latch; clock rise moves it to DAC latch.
// - Dual mode updates on every clock rise, interleaved on every second; no interleaved load until a first hold pulse.
// - Interleaved strobe rise stores word to channel one if steer high.
// - Hold high ignores pair clock; next rise after release loads both.
// - Pair clock divided by two: later loads only on every second rise.
// - Update rate up to 125 MSPS; host stays within it; pin sampling here caps clock rises at 25 MHz.
// - Power-down input has pull-down; left open keeps device enabled.
// - Power-down high switches output current off and enters sleep.
// - Sleep entry under 50 ns, wake about 5 us; outputs invalid meanwhile.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module ddil_top
    import ddil_pkg::*;
#(
    parameter int DATA_W   = DATA_W_DEF,
    parameter int WAKE_CYC = WAKE_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              mode,
    input  wire ddil_ctl_t         port1_ctl,
    input  wire ddil_ctl_t         port2_ctl,
    input  wire logic [DATA_W-1:0] port1_data,
    input  wire logic [DATA_W-1:0] port2_data,
    input  wire logic              power_down,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic      [DATA_W-1:0] ch1_true_current_out,
    output logic      [DATA_W-1:0] ch1_comp_current_out,
    output logic      [DATA_W-1:0] ch2_true_current_out,
    output logic      [DATA_W-1:0] ch2_comp_current_out,
    output logic                   output_valid
);
    logic [3:0]        rise;
    logic              w1_rise;
    logic              c1_rise;
    logic              w2_rise;
    logic              c2_rise;
    logic              channel_steer;
    logic              sync_hold;
    logic              mode_reg;
    logic              mode_chg;
    logic              dual;
    logic              il_update;
    logic              awake;
    logic              sleep_req;
    logic              ctrl_sleep_reg;
    logic              resp_reg;
    logic              bus_req;
    logic [31:0]       rd_next;
    logic [31:0]       avs_readdata_reg;
    logic [DATA_W-1:0] in1_reg;
    logic [DATA_W-1:0] in2_reg;
    logic [DATA_W-1:0] dac1_reg;
    logic [DATA_W-1:0] dac2_reg;
    logic [DATA_W-1:0] t1_reg;
    logic [DATA_W-1:0] k1_reg;
    logic [DATA_W-1:0] t2_reg;
    logic [DATA_W-1:0] k2_reg;
    logic              valid_reg;
    ddil_il_state_t    state_reg;
    ddil_il_state_t    state_next;

    function automatic logic [31:0] zext(input logic [DATA_W-1:0] v);
        zext = 32'(v);
    endfunction

    // Pins sampled every cycle; a rise needs a low sample first, so at most one edge
    // every two cycles (25 MHz at 50 MHz), below the 125 MSPS update rate
    ddil_edge_det #(
        .W (4)
    ) u_edge (
        .clk     (clk),
        .reset_n (reset_n),
        .sig     ({port2_ctl.clock, port2_ctl.strobe, port1_ctl.clock, port1_ctl.strobe}),
        .rise    (rise)
    );

    assign w1_rise       = rise[0];
    assign c1_rise       = rise[1];
    assign w2_rise       = rise[2];
    assign c2_rise       = rise[3];
    assign channel_steer = port2_ctl.strobe;
    assign sync_hold     = port2_ctl.clock;

    // Mode sampled every cycle by a clocked stage; a change restarts the sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= MODE_DUAL;
        end else begin
            mode_reg <= mode;
        end
    end

    assign mode_chg = (mode != mode_reg);
    assign dual     = (mode_reg == MODE_DUAL);

    // Interleave sequencer: wait for a hold pulse, then alternate load/skip
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IL_WAIT: begin
                if (sync_hold) begin
                    state_next = IL_HELD;
                end
            end
            IL_HELD: begin
                if (!sync_hold) begin
                    state_next = IL_LOAD;
                end
            end
            IL_LOAD: begin
                if (sync_hold) begin
                    state_next = IL_HELD;
                end else if (c1_rise) begin
                    state_next = IL_SKIP;
                end
            end
            IL_SKIP: begin
                if (sync_hold) begin
                    state_next = IL_HELD;
                end else if (c1_rise) begin
                    state_next = IL_LOAD;
                end
            end
            default: state_next = IL_WAIT;
        endcase
        if (mode_chg) begin
            state_next = IL_WAIT;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= IL_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pair clock is dead while held; loads on the first and every other rise
    assign il_update = !dual && (state_reg == IL_LOAD) && !sync_hold && c1_rise;

    // Input latches; unchanged unless a strobe rises (port one's for both when interleaved)
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in1_reg <= '0;
        end else if (w1_rise && (dual || channel_steer == STEER_CH1)) begin
            in1_reg <= port1_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in2_reg <= '0;
        end else if (dual && w2_rise) begin
            in2_reg <= port2_data;
        end else if (!dual && w1_rise && channel_steer != STEER_CH1) begin
            in2_reg <= port1_data;
        end
    end

    // DAC latches; a clock rising with its strobe takes the older word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac1_reg <= '0;
        end else if ((dual && c1_rise) || il_update) begin
            dac1_reg <= in1_reg;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac2_reg <= '0;
        end else if ((dual && c2_rise) || il_update) begin
            dac2_reg <= in2_reg;
        end
    end

    // Pad pull-down keeps an open power-down pin low, so sleep is opt
    assign sleep_req = power_down || ctrl_sleep_reg;

    ddil_sleep_ctl #(
        .WAKE_CYC (WAKE_CYC)
    ) u_sleep (
        .clk       (clk),
        .reset_n   (reset_n),
        .sleep_req (sleep_req),
        .awake     (awake)
    );

    // Current drive codes; both zero while the current is switched off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            t1_reg    <= '0;
            k1_reg    <= '0;
            t2_reg    <= '0;
            k2_reg    <= '0;
            valid_reg <= 1'b0;
        end else if (awake) begin
            t1_reg    <= dac1_reg;
            k1_reg    <= ~dac1_reg;
            t2_reg    <= dac2_reg;
            k2_reg    <= ~dac2_reg;
            valid_reg <= 1'b1;
        end else begin
            t1_reg    <= '0;
            k1_reg    <= '0;
            t2_reg    <= '0;
            k2_reg    <= '0;
            valid_reg <= 1'b0;
        end
    end

    assign ch1_true_current_out = t1_reg;
    assign ch1_comp_current_out = k1_reg;
    assign ch2_true_current_out = t2_reg;
    assign ch2_comp_current_out = k2_reg;
    assign output_valid         = valid_reg;

    // Avalon slave: one wait cycle, then the access completes
    assign bus_req         = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !resp_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_reg <= 1'b0;
        end else begin
            resp_reg <= bus_req && !resp_reg;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_sleep_reg <= CTRL_SLEEP_RST;
        end else if (avs_write && resp_reg && avs_address == OFS_CTRL) begin
            ctrl_sleep_reg <= avs_writedata[CTRL_SLEEP_BIT];
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (avs_address)
            OFS_CTRL: rd_next[CTRL_SLEEP_BIT] = ctrl_sleep_reg;
            OFS_STATUS: begin
                rd_next[ST_MODE_BIT]   = mode_reg;
                rd_next[ST_AWAKE_BIT]  = awake;
                rd_next[ST_SYNCED_BIT] = (state_reg == IL_LOAD) || (state_reg == IL_SKIP);
                rd_next[ST_PHASE_BIT]  = (state_reg == IL_SKIP);
            end
            OFS_CODE1: rd_next = zext(dac1_reg);
            OFS_CODE2: rd_next = zext(dac2_reg);
            default:   rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !resp_reg) begin
            avs_readdata_reg <= rd_next;
        end
    end

    assign avs_readdata = avs_readdata_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    dual_input_capture_a: assert property (
        dual && w1_rise |=> in1_reg == $past(port1_data))
        else $error("dual strobe did not capture port one word");
    steer_ch1_a: assert property (
        !dual && w1_rise && channel_steer |=> in1_reg == $past(port1_data) && $stable(in2_reg))
        else $error("steer high did not route to channel one");
    steer_ch2_a: assert property (
        !dual && w1_rise && !channel_steer |=> in2_reg == $past(port1_data) && $stable(in1_reg))
        else $error("steer low did not route to channel two");
    dual_dac_update_a: assert property (
        dual && c2_rise |=> dac2_reg == $past(in2_reg))
        else $error("dual clock did not load channel two");
    hold_blocks_a: assert property (
        !dual && sync_hold |=> $stable(dac1_reg) && $stable(dac2_reg))
        else $error("DAC latch changed during sync hold");
    release_arms_a: assert property (
        state_reg == IL_HELD && !sync_hold && !mode_chg |=> state_reg == IL_LOAD)
        else $error("hold release did not arm the first load");
    divide_two_a: assert property (
        il_update && !mode_chg |=> state_reg == IL_SKIP)
        else $error("interleaved load did not skip the next pair clock rise");
    no_edge_hold_a: assert property (
        !w1_rise && !w2_rise |=> $stable(in1_reg) && $stable(in2_reg))
        else $error("input latch changed without a strobe");
    comp_sum_a: assert property (
        valid_reg |-> (ch1_true_current_out ^ ch1_comp_current_out) == '1)
        else $error("complement output does not carry the remainder");
    sleep_off_a: assert property (
        sleep_req |-> ##2 ch1_true_current_out == '0 && ch2_comp_current_out == '0 && !output_valid)
        else $error("output current not off within two cycles of sleep");

    dual_update_c: cover property (dual && c1_rise && c2_rise);
    il_update_c: cover property (il_update ##[1:20] il_update);
    steer_two_c: cover property (!dual && w1_rise && !channel_steer);
    wake_done_c: cover property ($rose(output_valid));
endmodule // ddil_top

// File: test/ddil_host_model.sv
// Purpose: Host data source driving the sample ports, strobes and clocks
// Assumes: Pins change by non-blocking assignment just after a clk edge
// Notes:   A released data bus shows the inverse of the last word
`timescale 1ns/1ps
module ddil_host_model
    import ddil_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              clk,
    output ddil_ctl_t              port1_ctl,
    output ddil_ctl_t              port2_ctl,
    output logic      [DATA_W-1:0] port1_data,
    output logic      [DATA_W-1:0] port2_data
);
    initial begin
        port1_ctl  = '0;
        port2_ctl  = '0;
        port1_data = '0;
        port2_data = '0;
    end

    // Strobe pulse; the clock may rise with it but never just after it
    task automatic dual_write(input int ch, input logic [DATA_W-1:0] d, input logic with_clk);
        @(posedge clk);
        if (ch == 1) begin
            port1_data <= d;
            port1_ctl  <= '{strobe: 1'b1, clock: with_clk};
        end else begin
            port2_data <= d;
            port2_ctl  <= '{strobe: 1'b1, clock: with_clk};
        end
        @(posedge clk);
        if (ch == 1) begin
            port1_ctl  <= '0;
            port1_data <= ~d;
        end else begin
            port2_ctl  <= '0;
            port2_data <= ~d;
        end
    endtask

    task automatic dual_clock(input int ch);
        @(posedge clk);
        if (ch == 1) port1_ctl.clock <= 1'b1;
        else port2_ctl.clock <= 1'b1;
        @(posedge clk);
        if (ch == 1) port1_ctl.clock <= 1'b0;
        else port2_ctl.clock <= 1'b0;
    endtask

    task automatic il_write(input logic steer, input logic [DATA_W-1:0] d);
        @(posedge clk);
        port2_ctl.strobe <= steer;
        @(posedge clk);
        port1_data       <= d;
        port1_ctl.strobe <= 1'b1;
        @(posedge clk);
        port1_ctl.strobe <= 1'b0;
        port1_data       <= ~d;
    endtask

    task automatic il_clock();
        @(posedge clk);
        port1_ctl.clock <= 1'b1;
        @(posedge clk);
        port1_ctl.clock <= 1'b0;
    endtask

    // Sync hold pulse, optionally with a pair clock pulse inside it
    task automatic il_hold(input logic with_clk);
        @(posedge clk);
        port2_ctl.clock <= 1'b1;
        @(posedge clk);
        port1_ctl.clock <= with_clk;
        @(posedge clk);
        port1_ctl.clock <= 1'b0;
        @(posedge clk);
        port2_ctl.clock <= 1'b0;
    endtask
endmodule // ddil_host_model

// File: test/dual_dac_input_latch_interface_test.sv
// Purpose: Self-checking bench for the dual converter input latch block
// Assumes: Short wake count; register bus driven as an Avalon-MM master
// Notes:   Each scenario task drives and judges before returning
`timescale 1ns/1ps
module dual_dac_input_latch_interface_test;
    import ddil_pkg::*;
    localparam int DW   = DATA_W_DEF;
    localparam int WAKE = 4;

    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          mode = 1'b1;
    logic          power_down = 1'b0;
    logic [3:0]    avs_address = '0;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = '0;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    ddil_ctl_t     port1_ctl;
    ddil_ctl_t     port2_ctl;
    logic [DW-1:0] port1_data;
    logic [DW-1:0] port2_data;
    logic [DW-1:0] ch1_true_current_out;
    logic [DW-1:0] ch1_comp_current_out;
    logic [DW-1:0] ch2_true_current_out;
    logic [DW-1:0] ch2_comp_current_out;
    logic          output_valid;
    logic [31:0]   rd;
    int            mismatches = 0;
    int            checks = 0;
    int            cycles = 0;

    always #10 clk = ~clk;

    ddil_host_model #(.DATA_W(DW)) u_ddil_host_model (
        .clk(clk), .port1_ctl(port1_ctl), .port2_ctl(port2_ctl),
        .port1_data(port1_data), .port2_data(port2_data));

    ddil_top #(.DATA_W(DW), .WAKE_CYC(WAKE)) u_ddil_top (
        .clk(clk), .reset_n(reset_n), .mode(mode), .port1_ctl(port1_ctl), .port2_ctl(port2_ctl),
        .port1_data(port1_data), .port2_data(port2_data), .power_down(power_down),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ch1_true_current_out(ch1_true_current_out), .ch1_comp_current_out(ch1_comp_current_out),
        .ch2_true_current_out(ch2_true_current_out), .ch2_comp_current_out(ch2_comp_current_out),
        .output_valid(output_valid));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until the edge that sees waitrequest low; data taken there
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_read    <= 1'b1;
        avs_address <= a;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_write     <= 1'b1;
        avs_address   <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        avs_write <= 1'b0;
    endtask

    // Outputs settle one edge after the DAC latch load; two edges waited here
    task automatic outs(input logic [DW-1:0] e1, input logic [DW-1:0] e2);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ch1_true", {18'h0, e1}, {18'h0, ch1_true_current_out});
        chk("ch1_comp", {18'h0, ~e1}, {18'h0, ch1_comp_current_out});
        chk("ch2_true", {18'h0, e2}, {18'h0, ch2_true_current_out});
        chk("ch2_comp", {18'h0, ~e2}, {18'h0, ch2_comp_current_out});
    endtask

    task automatic reset_and_map();
        outs(14'h0000, 14'h0000);
        chk("output_valid", 32'h0000_0001, {31'h0, output_valid});
        bus_read(OFS_STATUS, rd);
        chk("status", 32'h0000_0003, rd & 32'h0000_0003);
        bus_read(4'h2, rd);
        chk("unmapped", 32'h0000_0000, rd);
    endtask

    task automatic dual_port();
        u_ddil_host_model.dual_write(1, 14'h3FFF, 1'b0);
        u_ddil_host_model.dual_write(2, 14'h0155, 1'b0);
        u_ddil_host_model.dual_clock(1);
        outs(14'h3FFF, 14'h0000);
        u_ddil_host_model.dual_clock(2);
        outs(14'h3FFF, 14'h0155);
        bus_read(OFS_CODE2, rd);
        chk("code2", 32'h0000_0155, rd);
        u_ddil_host_model.dual_write(1, 14'h2AAA, 1'b1);
        outs(14'h3FFF, 14'h0155);
        u_ddil_host_model.dual_clock(1);
        outs(14'h2AAA, 14'h0155);
    endtask

    task automatic interleaved();
        @(posedge clk);
        mode <= 1'b0;
        u_ddil_host_model.il_write(STEER_CH1, 14'h1234);
        u_ddil_host_model.il_write(~STEER_CH1, 14'h0ABC);
        u_ddil_host_model.il_clock();
        outs(14'h2AAA, 14'h0155);
        u_ddil_host_model.il_hold(1'b1);
        outs(14'h2AAA, 14'h0155);
        u_ddil_host_model.il_clock();
        outs(14'h1234, 14'h0ABC);
        bus_read(OFS_STATUS, rd);
        chk("status_phase", 32'h0000_0003, {30'h0, rd[3:2]});
        u_ddil_host_model.il_write(STEER_CH1, 14'h0F0F);
        u_ddil_host_model.il_write(~STEER_CH1, 14'h3001);
        u_ddil_host_model.il_clock();
        outs(14'h1234, 14'h0ABC);
        u_ddil_host_model.il_clock();
        outs(14'h0F0F, 14'h3001);
    endtask

    task automatic sleep_wake();
        int n;
        @(posedge clk);
        power_down <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("sleep_valid", 32'h0000_0000, {31'h0, output_valid});
        chk("sleep_ch1", 32'h0000_0000, {18'h0, ch1_true_current_out});
        @(posedge clk);
        power_down <= 1'b0;
        repeat (WAKE) @(posedge clk);
        @(negedge clk);
        chk("early_valid", 32'h0000_0000, {31'h0, output_valid});
        outs(14'h0F0F, 14'h3001);
        chk("wake_valid", 32'h0000_0001, {31'h0, output_valid});
        bus_write(OFS_CTRL, 32'h0000_0001);
        bus_read(OFS_STATUS, rd);
        chk("soft_sleep", 32'h0000_0000, rd & 32'h0000_0002);
        bus_write(OFS_CTRL, 32'h0000_0000);
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (output_valid === 1'b1) break;
        end
        chk("soft_wake", 32'h0000_0001, {31'h0, output_valid});
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reset_and_map();
        dual_port();
        interleaved();
        sleep_wake();
        conclude();
    end
endmodule // dual_dac_input_latch_interface_test
